// File: pkg/irq_ctrl_pkg.sv
// Purpose: Shared constants and carrier types for the multilevel
//          interrupt controller.
// Assumes: Register bus is APB with 32-bit data, one word per register.
// Notes:   Register offsets are word indices; byte address is 4x index.
package irq_ctrl_pkg;

  // Bus and vector widths
  localparam int APB_AW = 12; // APB address width
  localparam int VEC_W  = 8;  // Vector number width
  localparam int ADDR_W = 16; // Program word address

  // Register indices (byte address = 4 * index)
  localparam logic [1:0] STATUS_IDX = 2'h0; // Executing flags
  localparam logic [1:0] LASTV_IDX  = 2'h1; // Last low vector
  localparam logic [1:0] CTRL_IDX   = 2'h2; // Level enables

  // Field positions, status register
  localparam int NMI_EX_BIT = 7; // NMI executing
  localparam int HI_EX_BIT  = 2; // High executing
  localparam int MED_EX_BIT = 1; // Medium executing
  localparam int LO_EX_BIT  = 0; // Low executing

  // Field positions, control register
  localparam int RR_EN_BIT  = 7; // Round-robin enable
  localparam int VSEL_BIT   = 6; // Vector table select
  localparam int HI_EN_BIT  = 2; // High level enable
  localparam int MED_EN_BIT = 1; // Medium level enable
  localparam int LO_EN_BIT  = 0; // Low level enable

  // Values after reset
  localparam logic [7:0] STATUS_RST = 8'h00; // Nothing executing
  localparam logic [7:0] LASTV_RST  = 8'h00; // Static order
  localparam logic [7:0] CTRL_RST   = 8'h00; // All levels off

  // Writable control bits (reserved 5:3 kept zero)
  localparam logic [7:0] CTRL_WMASK = 8'h87; // Without vector select

  // Vector placement
  localparam logic [ADDR_W-1:0] RESET_APP_ADDR = 16'h0000; // App reset
  localparam logic [ADDR_W-1:0] VEC_TABLE_OFS  = 16'h0002; // Table offset
  localparam int VEC_STRIDE_SHIFT = 1; // Two words per vector

  // Per-source level code
  typedef enum logic [1:0] {
    LVL_OFF = 2'b00, // Source disabled
    LVL_LO  = 2'b01, // Low level
    LVL_MED = 2'b10, // Medium level
    LVL_HI  = 2'b11  // High level
  } level_t;

  // Acknowledge bundle handed to the core
  typedef struct packed {
    logic               is_nmi; // Non-maskable ack
    level_t             level;  // Level when maskable
    logic [VEC_W-1:0]   vector; // Vector number
    logic [ADDR_W-1:0]  addr;   // Vector word address
  } ack_t;

endpackage

// File: design/multilevel_irq_controller.sv
// Purpose: Multilevel interrupt controller: level/vector arbitration,
//          optional low-level round-robin, executing-level tracking,
//          vector table placement, APB register slave.
// Assumes: Requests, core handshakes and the fuse are on clk_i.
// Notes:   Zero-wait APB slave; registered ack to the core.
// Contract
// (RL1) Two-bit level: off, low, medium, high
// (RL2) Higher level preempts lower; lower resumes after
// (RL3) Pick by level first, then priority
// (RL4) Only low level may use round-robin
// (RL5) Static: lowest vector wins within level
// (RL6) Last low vector gets lowest priority next
// (RL7) Fuse picks reset address; select picks table
// (RL8) Status bit 7 marks NMI handler running
// (RL9) Status bit 2 marks high handler active
// (RL10) Status bit 1 marks medium handler active
// (RL11) Status bit 0 marks low handler active
// (RL12) Last-vector register captures acked low vectors
// (RL13) Last vector kept when round-robin off
// (RL14) Control bit 7 enables low round-robin
// (RL15) Control bit 6 writable only when unlocked
// (RL16) Control bits 2:0 enable high/medium/low
// (RL17) Disabling a level takes effect one cycle later
// (RL18) Software writes zeros to reserved bits
// (RL19) Maskable needs global interrupt enable too
// (RL20) NMI never preempted; lowest NMI vector first
// (RL21) One ack at a time; flags update with it
`timescale 1ns/10ps
module multilevel_irq_controller
  import irq_ctrl_pkg::*;
#(
  parameter int                NUM_SRC   = 16,     // Maskable sources
  parameter int                NUM_NMI   = 1,      // Non-maskable sources
  parameter logic [ADDR_W-1:0] BOOT_ADDR = 16'h4000 // Boot section start
)(
  input  wire logic                      clk_i,           // Clock, 50 MHz
  input  wire logic                      reset_n_i,       // Sync reset, low
  input  wire logic                      psel_i,          // APB select
  input  wire logic                      penable_i,       // APB enable
  input  wire logic                      pwrite_i,        // APB write
  input  wire logic [APB_AW-1:0]         paddr_i,         // APB address
  input  wire logic [31:0]               pwdata_i,        // APB write data
  output logic      [31:0]               prdata_o,        // APB read data
  output logic                           pready_o,        // APB ready
  output logic                           pslverr_o,       // APB error
  input  wire logic [NUM_SRC-1:0]        irq_req_i,       // Maskable reqs
  input  wire logic [NUM_SRC-1:0][1:0]   irq_level_i,     // Level codes
  input  wire logic [NUM_NMI-1:0]        nmi_req_i,       // NMI requests
  input  wire logic                      global_ie_i,     // Core I bit
  input  wire logic                      core_ready_i,    // Core can take
  input  wire logic                      irq_ret_i,       // Return pulse
  input  wire logic                      ccp_unlock_i,    // Protect unlock
  input  wire logic                      boot_reset_fuse_i, // Reset fuse
  output logic                           ack_valid_o,     // Ack pulse
  output ack_t                           ack_o,           // Ack bundle
  output logic      [ADDR_W-1:0]         reset_addr_o     // Reset address
);

  // Vectors 0..NUM_NMI-1 are NMIs, maskable sources follow them
  initial
  begin
    if (NUM_SRC < 1 || NUM_NMI < 1 || NUM_SRC + NUM_NMI > 256)
      $error("Vector count must fit the 8-bit vector number");
  end

  logic [7:0]          status_ff;      // Executing-level flags
  logic [7:0]          lastv_ff;       // Last acked low vector
  logic [7:0]          ctrl_ff;        // Control register
  logic [2:0]          en_dly_ff;      // Level enables, one cycle late
  logic                ack_valid_ff;   // Registered ack strobe
  ack_t                ack_ff;         // Registered ack bundle
  logic [ADDR_W-1:0]   reset_addr_ff;  // Registered reset address

  logic [NUM_SRC-1:0]  hi_mask;        // Eligible high requests
  logic [NUM_SRC-1:0]  med_mask;       // Eligible medium requests
  logic [NUM_SRC-1:0]  lo_mask;        // Eligible low requests
  logic [NUM_SRC-1:0]  rr_mask;        // Low requests after last vector
  logic                win_valid;      // Some request may be acked
  ack_t                win;            // Winner of this cycle
  logic                take;           // Ack issued this cycle
  logic [1:0]          reg_idx;        // Decoded register index
  logic                reg_hit;        // Address maps to a register
  logic                wr_en;          // Write completes this edge
  logic [VEC_W-1:0]    lo_vec_base;    // Vector of source 0

  // Lowest set index of a source mask
  function automatic logic [VEC_W-1:0] first_src(
    input logic [NUM_SRC-1:0] m
  );
    logic [VEC_W-1:0] r;
    r = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (m[i])
        r = VEC_W'(i);
    end
    return r;
  endfunction

  // Lowest set index of the NMI mask
  function automatic logic [VEC_W-1:0] first_nmi(
    input logic [NUM_NMI-1:0] m
  );
    logic [VEC_W-1:0] r;
    r = '0;
    for (int i = NUM_NMI - 1; i >= 0; i--)
    begin
      if (m[i])
        r = VEC_W'(i);
    end
    return r;
  endfunction

  // Word address of a vector in the selected table
  function automatic logic [ADDR_W-1:0] vec_addr(
    input logic [VEC_W-1:0] v,
    input logic             sel
  );
    logic [ADDR_W-1:0] base;
    base = sel ? ADDR_W'(BOOT_ADDR + VEC_TABLE_OFS)
               : VEC_TABLE_OFS; // [RL7]
    return ADDR_W'(base + (ADDR_W'(v) << VEC_STRIDE_SHIFT));
  endfunction

  assign lo_vec_base = VEC_W'(NUM_NMI);

  // Sort requests by level code; a level counts only while its delayed
  // enable and the global enable are set
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++)
    begin : g_src
      always_comb
      begin
        hi_mask[g]  = irq_req_i[g] && irq_level_i[g] == LVL_HI // [RL1]
                      && en_dly_ff[HI_EN_BIT] && global_ie_i; // [RL16] [RL19]
        med_mask[g] = irq_req_i[g] && irq_level_i[g] == LVL_MED // [RL1]
                      && en_dly_ff[MED_EN_BIT] && global_ie_i; // [RL16] [RL19]
        lo_mask[g]  = irq_req_i[g] && irq_level_i[g] == LVL_LO // [RL1]
                      && en_dly_ff[LO_EN_BIT] && global_ie_i; // [RL16] [RL19]
        // Vectors above the last acked low one come first
        rr_mask[g]  = lo_mask[g]
                      && (VEC_W'(g) + lo_vec_base) > lastv_ff; // [RL6]
      end
    end
  endgenerate

  // Arbiter: NMI, then high, medium, low, each only above the running
  // level; within a level the lowest vector wins, except at low level with round-robin on
  always_comb
  begin
    win_valid  = 1'b0;
    win.is_nmi = 1'b0;
    win.level  = LVL_OFF;
    win.vector = '0;
    if (|nmi_req_i && !status_ff[NMI_EX_BIT]) // [RL20]
    begin
      win_valid  = 1'b1;
      win.is_nmi = 1'b1;
      win.vector = first_nmi(nmi_req_i); // [RL20]
    end
    else if (status_ff[NMI_EX_BIT])
    begin
      // Nothing interrupts a running NMI handler
      win_valid  = 1'b0; // [RL20]
    end
    else if (|hi_mask && !status_ff[HI_EX_BIT]) // [RL2] [RL3]
    begin
      win_valid  = 1'b1;
      win.level  = LVL_HI;
      win.vector = first_src(hi_mask) + lo_vec_base; // [RL4] [RL5]
    end
    else if (|med_mask && !status_ff[HI_EX_BIT]
             && !status_ff[MED_EX_BIT]) // [RL2] [RL3]
    begin
      win_valid  = 1'b1;
      win.level  = LVL_MED;
      win.vector = first_src(med_mask) + lo_vec_base; // [RL4] [RL5]
    end
    else if (|lo_mask && status_ff[2:0] == 3'b000) // [RL2] [RL3]
    begin
      win_valid  = 1'b1;
      win.level  = LVL_LO;
      // Round-robin wraps to the lowest vector when none lies above
      if (ctrl_ff[RR_EN_BIT] && |rr_mask) // [RL14] [RL6]
        win.vector = first_src(rr_mask) + lo_vec_base;
      else
        win.vector = first_src(lo_mask) + lo_vec_base; // [RL5]
    end
    win.addr = vec_addr(win.vector, ctrl_ff[VSEL_BIT]); // [RL7]
  end

  // A return and a new ack never share a cycle; the return goes first
  // so the flags never see a set and a clear at once
  assign take = win_valid && core_ready_i && !irq_ret_i; // [RL21]

  // Executing-level flags: set with the ack, the highest one cleared by
  // the return that ends its handler
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      status_ff <= STATUS_RST;
    else if (irq_ret_i)
    begin
      if (status_ff[NMI_EX_BIT])
        status_ff[NMI_EX_BIT] <= 1'b0; // [RL8]
      else if (status_ff[HI_EX_BIT])
        status_ff[HI_EX_BIT] <= 1'b0; // [RL9]
      else if (status_ff[MED_EX_BIT])
        status_ff[MED_EX_BIT] <= 1'b0; // [RL10]
      else
        status_ff[LO_EX_BIT] <= 1'b0; // [RL11]
    end
    else if (take)
    begin
      // Lower flags stay set while their handler is suspended
      if (win.is_nmi)
        status_ff[NMI_EX_BIT] <= 1'b1; // [RL8]
      else if (win.level == LVL_HI)
        status_ff[HI_EX_BIT] <= 1'b1; // [RL9]
      else if (win.level == LVL_MED)
        status_ff[MED_EX_BIT] <= 1'b1; // [RL10]
      else
        status_ff[LO_EX_BIT] <= 1'b1; // [RL11]
    end
  end

  // Ack strobe and bundle to the core, one per cycle at most
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      ack_valid_ff <= 1'b0;
      ack_ff       <= '0;
    end
    else
    begin
      ack_valid_ff <= take;                                    // [RL21]
      if (take)
        ack_ff <= win;
    end
  end

  // APB decode: word aligned, three registers, rest answers an error
  assign reg_idx = paddr_i[3:2];
  assign reg_hit = paddr_i[1:0] == 2'b00
                   && paddr_i[APB_AW-1:4] == '0
                   && reg_idx <= CTRL_IDX;
  assign wr_en   = psel_i && penable_i && pwrite_i && reg_hit;

  // Last low vector: hardware capture wins over a software write that
  // lands in the same cycle, so an ack is never forgotten
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      lastv_ff <= LASTV_RST;
    else if (take && !win.is_nmi && win.level == LVL_LO
             && ctrl_ff[RR_EN_BIT])
      lastv_ff <= win.vector; // [RL12]
    else if (wr_en && reg_idx == LASTV_IDX)
      lastv_ff <= pwdata_i[7:0]; // [RL12]
    // Otherwise held, even with round-robin off [RL13]
  end

  // Control register; vector select changes only while unlocked
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      ctrl_ff <= CTRL_RST;
    else if (wr_en && reg_idx == CTRL_IDX)
    begin
      ctrl_ff <= pwdata_i[7:0] & CTRL_WMASK; // [RL14] [RL16]
      if (ccp_unlock_i)
        ctrl_ff[VSEL_BIT] <= pwdata_i[VSEL_BIT]; // [RL15]
      else
        ctrl_ff[VSEL_BIT] <= ctrl_ff[VSEL_BIT]; // [RL15]
    end
  end

  // Enables reach the arbiter one cycle late, so a request already on
  // its way when software disables a level is still accepted
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      en_dly_ff <= 3'b000;
    else
      en_dly_ff <= ctrl_ff[HI_EN_BIT:LO_EN_BIT];               // [RL17]
  end

  // Reset address follows the fuse; registered to keep outputs clean
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      reset_addr_ff <= RESET_APP_ADDR;
    else
      reset_addr_ff <= boot_reset_fuse_i ? RESET_APP_ADDR
                                         : BOOT_ADDR;          // [RL7]
  end

  // Read mux; reserved bits read as zero
  always_comb
  begin
    prdata_o = 32'h0000_0000;
    if (reg_hit)
    begin
      case (reg_idx)
        STATUS_IDX: prdata_o = {24'h00_0000, status_ff};
        LASTV_IDX:  prdata_o = {24'h00_0000, lastv_ff};
        CTRL_IDX:   prdata_o = {24'h00_0000, ctrl_ff};
        default:    prdata_o = 32'h0000_0000;
      endcase
    end
  end

  // Zero-wait slave; errors only on unmapped addresses
  assign pready_o     = 1'b1;
  assign pslverr_o    = psel_i && penable_i && !reg_hit;
  assign ack_valid_o  = ack_valid_ff;
  assign ack_o        = ack_ff;
  assign reset_addr_o = reset_addr_ff;

  // Checks on the arbiter and the flags
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_lo_take;
    take && !win.is_nmi && win.level == LVL_LO;
  endsequence

  a_nmi_no_preempt: assert property ( // [RL20]
    status_ff[NMI_EX_BIT] && !irq_ret_i |=> !ack_valid_o)
    else $error("Ack issued while NMI handler runs");

  a_nmi_flag_set: assert property ( // [RL8]
    take && win.is_nmi |=> status_ff[NMI_EX_BIT] && ack_valid_o)
    else $error("NMI ack did not set its flag");

  a_nmi_ret_clr: assert property ( // [RL8]
    irq_ret_i && status_ff[NMI_EX_BIT]
      |=> !status_ff[NMI_EX_BIT] && $stable(status_ff[2:0]))
    else $error("Return from NMI cleared wrong flag");

  a_hi_flag_set: assert property ( // [RL9]
    take && !win.is_nmi && win.level == LVL_HI
      |=> status_ff[HI_EX_BIT] && $stable(status_ff[1:0]))
    else $error("High ack flag update wrong");

  a_med_flag_set: assert property ( // [RL10]
    take && !win.is_nmi && win.level == LVL_MED
      |=> status_ff[MED_EX_BIT])
    else $error("Medium ack did not set its flag");

  a_lo_flag_set: assert property ( // [RL11]
    s_lo_take |=> status_ff[LO_EX_BIT] && ack_o.level == LVL_LO)
    else $error("Low ack did not set its flag");

  a_level_order: assert property ( // [RL3]
    s_lo_take |-> !(|hi_mask) && !(|med_mask) && !(|nmi_req_i))
    else $error("Low acked over a higher request");

  a_hi_lowest_vec: assert property ( // [RL5]
    take && !win.is_nmi && win.level == LVL_HI
      |-> win.vector == first_src(hi_mask) + lo_vec_base)
    else $error("High winner is not lowest vector");

  a_en_delay: assert property ( // [RL17]
    ack_valid_o && !ack_o.is_nmi && ack_o.level == LVL_LO
      |-> $past(ctrl_ff[LO_EN_BIT], 2))
    else $error("Low ack after enable had cleared");

  a_gie_needed: assert property ( // [RL19]
    ack_valid_o && !ack_o.is_nmi |-> $past(global_ie_i))
    else $error("Maskable ack without global enable");

  a_rr_capture: assert property ( // [RL12]
    s_lo_take ##0 ctrl_ff[RR_EN_BIT] |=> lastv_ff == ack_o.vector)
    else $error("Last low vector not captured");

  a_rr_hold: assert property ( // [RL13]
    !ctrl_ff[RR_EN_BIT] && !(wr_en && reg_idx == LASTV_IDX)
      |=> $stable(lastv_ff))
    else $error("Last low vector changed while held");

  a_vsel_lock: assert property ( // [RL15]
    !(wr_en && reg_idx == CTRL_IDX && ccp_unlock_i)
      |=> $stable(ctrl_ff[VSEL_BIT]))
    else $error("Vector select changed while locked");

endmodule

// File: testbench/core_partner.sv
// Purpose: Core and peripheral stand-in
// Assumes: Flags set by the bench, cleared by their ack
// Notes:   A slow core withholds ready in a rotating pattern
`timescale 1ns/10ps
module core_partner
  import irq_ctrl_pkg::*;
#(
  parameter int NUM_SRC = 8,                // Maskable sources
  parameter int NUM_NMI = 1                 // Non-maskable sources
)(
  input  wire logic               clk_i,        // Clock
  input  wire logic               reset_n_i,    // Sync reset, low
  input  wire logic [NUM_SRC-1:0] raise_i,      // Set peripheral flags
  input  wire logic               raise_nmi_i,  // Set NMI flag 0
  input  wire logic               drop_i,       // Clear all flags
  input  wire logic               slow_i,       // Stall core ready
  input  wire logic               ack_valid_i,  // Ack pulse
  input  wire ack_t               ack_i,        // Ack bundle
  output logic      [NUM_SRC-1:0] irq_req_o,    // Maskable requests
  output logic      [NUM_NMI-1:0] nmi_req_o,    // NMI requests
  output logic                    core_ready_o  // Core accepts
);
  logic [7:0] stall_ff;                     // Ready pattern when slow

  // Flags hold until their own ack; dropping early would hide a lost ack
  always_ff @(posedge clk_i)
  begin
    for (int j = 0; j < NUM_SRC; j++)
      if (!reset_n_i || drop_i)
        irq_req_o[j] <= 1'b0;
      else if (raise_i[j])
        irq_req_o[j] <= 1'b1;
      else if (ack_valid_i && !ack_i.is_nmi &&
               ack_i.vector == VEC_W'(j + NUM_NMI))
        irq_req_o[j] <= 1'b0;
    for (int i = 0; i < NUM_NMI; i++)
      if (!reset_n_i || drop_i)
        nmi_req_o[i] <= 1'b0;
      else if (raise_nmi_i && i == 0)
        nmi_req_o[i] <= 1'b1;
      else if (ack_valid_i && ack_i.is_nmi && ack_i.vector == VEC_W'(i))
        nmi_req_o[i] <= 1'b0;
  end

  // Rotating stall pattern: ready comes late but always comes
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      stall_ff <= 8'hA5;
    else
      stall_ff <= {stall_ff[0], stall_ff[7:1]};
  end

  assign core_ready_o = !slow_i || stall_ff[0];
endmodule

// File: testbench/tb_top.sv
// Purpose: Self-checking bench for the multilevel interrupt controller
// Assumes: Zero-wait APB slave; ack one cycle after the take edge
// Notes:   Random levels are checked against a bench arbitration model
`timescale 1ns/10ps
module tb_top;
  import irq_ctrl_pkg::*;
  localparam int                NS   = 8;        // Maskable sources
  localparam logic [ADDR_W-1:0] BOOT = 16'h4000; // Boot section start
  logic                clk_i = 1'b0;     // Clock
  logic                reset_n_i = 1'b0; // Reset, low
  logic                psel_i = 1'b0;    // APB select
  logic                penable_i = 1'b0; // APB enable
  logic                pwrite_i = 1'b0;  // APB direction
  logic [APB_AW-1:0]   paddr_i = '0;     // APB address
  logic [31:0]         pwdata_i = '0;    // APB write data
  logic [31:0]         prdata_o;         // APB read data
  logic                pready_o;         // APB ready
  logic                pslverr_o;        // APB error
  logic [NS-1:0]       irq_req_i;        // From partner
  logic [NS-1:0][1:0]  irq_level_i = '0; // Level codes
  logic [0:0]          nmi_req_i;        // From partner
  logic                core_ready_i;     // From partner
  logic                global_ie_i = 1'b1; // Core I bit
  logic                irq_ret_i = 1'b0; // Return pulse
  logic                ccp_unlock_i = 1'b0; // Protection unlock
  logic                fuse_i = 1'b1;    // Boot reset fuse
  logic                ack_valid_o;      // Ack pulse
  ack_t                ack_o;            // Ack bundle
  logic [ADDR_W-1:0]   reset_addr_o;     // Reset address
  logic [NS-1:0]       raise = '0;       // Flag set pulses
  logic                raise_nmi = 1'b0; // NMI set pulse
  logic                drop = 1'b0;      // Flag clear pulse
  logic                slow = 1'b0;      // Core stalls
  logic [31:0]         seed = 32'h83B49C96; // Xorshift state
  int                  failures = 0;     // Mismatches
  int                  check_count = 0;  // Comparisons
  int                  cycles = 0;       // Timeout count

  multilevel_irq_controller #(.NUM_SRC(NS), .NUM_NMI(1), .BOOT_ADDR(BOOT))
    u_dut (.clk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
           .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .irq_req_i,
           .irq_level_i, .nmi_req_i, .global_ie_i, .core_ready_i, .irq_ret_i,
           .ccp_unlock_i, .boot_reset_fuse_i(fuse_i), .ack_valid_o,
           .ack_o, .reset_addr_o);
  core_partner #(.NUM_SRC(NS), .NUM_NMI(1))
    u_partner (.clk_i, .reset_n_i, .raise_i(raise), .raise_nmi_i(raise_nmi),
               .drop_i(drop), .slow_i(slow), .ack_valid_i(ack_valid_o),
               .ack_i(ack_o), .irq_req_o(irq_req_i),
               .nmi_req_o(nmi_req_i), .core_ready_o(core_ready_i));

  initial
    forever #10 clk_i = ~clk_i;

  // Hang guard: the whole run needs about a thousand cycles
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string w, input logic [31:0] s, x);
    check_count++;
    if (s !== x)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", w, x, s);
    end
  endtask

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Bench arbiter: highest level, then lowest source index
  function automatic int win(input logic [NS-1:0] m,
                             input logic [NS-1:0][1:0] l);
    int b;
    b = -1;
    for (int j = 0; j < NS; j++)
      if (m[j] && (b < 0 || l[j] > l[b]))
        b = j;
    return b;
  endfunction

  // Request held until the edge that samples pready high
  task automatic apb(input logic wr, input logic [APB_AW-1:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do
      @(posedge clk_i);
    while (pready_o !== 1'b1);
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wr(input logic [APB_AW-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd_chk(input string w, input logic [APB_AW-1:0] a,
                        input logic [31:0] x);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(w, q, x);
  endtask

  task automatic fire(input logic [NS-1:0] m, input logic nmi);
    @(posedge clk_i);
    raise <= m;
    raise_nmi <= nmi;
    @(posedge clk_i);
    raise <= '0;
    raise_nmi <= 1'b0;
  endtask

  task automatic iret();
    @(posedge clk_i);
    irq_ret_i <= 1'b1;
    @(posedge clk_i);
    irq_ret_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic quiet(input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      chk("no_ack", 32'(ack_valid_o), 32'h0);
    end
  endtask

  // Waits for an ack; vector 0 is the NMI
  task automatic serve(input int v, input logic [1:0] lv, input logic ivs);
    int                n;
    logic [ADDR_W-1:0] base;
    n = 0;
    base = ivs ? BOOT + 16'h0002 : 16'h0002;
    do
      @(posedge clk_i);
    while (ack_valid_o !== 1'b1 && ++n < 60);
    chk("ack_valid", 32'(ack_valid_o), 32'h1);
    chk("ack_vector", 32'(ack_o.vector), 32'(v));
    chk("ack_nmi", 32'(ack_o.is_nmi), 32'(v == 0));
    if (v != 0)
      chk("ack_level", 32'(ack_o.level), 32'(lv));
    chk("ack_addr", 32'(ack_o.addr), 32'(base + 16'(2 * v)));
  endtask

  initial
  begin
    logic [NS-1:0]      m;
    logic [NS-1:0][1:0] lv;
    int                 b;
    logic               e;
    logic [31:0]        q;
    repeat (6) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd_chk("status", 12'h000, 32'h0);
    rd_chk("last_vector", 12'h004, 32'h0);
    rd_chk("control", 12'h008, 32'h0);
    chk("reset_addr", 32'(reset_addr_o), 32'h0);
    fuse_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("reset_addr", 32'(reset_addr_o), 32'(BOOT));
    apb(1'b0, 12'h00C, 32'h0, q, e);
    chk("unmapped_err", 32'(e), 32'h1);
    $display("register test done");
    // Global enable off, level code off, level enable off
    irq_level_i[1] <= LVL_LO;
    global_ie_i <= 1'b0;
    wr(12'h008, 32'h07);
    fire(8'h03, 1'b0);
    quiet(8);
    global_ie_i <= 1'b1;
    serve(2, LVL_LO, 1'b0);
    iret();
    quiet(8);
    drop <= 1'b1;
    wr(12'h008, 32'h06);
    drop <= 1'b0;
    fire(8'h02, 1'b0);
    quiet(8);
    wr(12'h008, 32'h07);
    serve(2, LVL_LO, 1'b0);
    iret();
    $display("enable test done");
    // Nested preemption up to an NMI, then unwinding
    irq_level_i <= {LVL_HI, LVL_HI, LVL_OFF, LVL_HI, LVL_HI, LVL_OFF,
                    LVL_MED, LVL_LO};
    fire(8'h01, 1'b0);
    serve(1, LVL_LO, 1'b0);
    rd_chk("status", 12'h000, 32'h01);
    fire(8'h02, 1'b0);
    serve(2, LVL_MED, 1'b0);
    rd_chk("status", 12'h000, 32'h03);
    fire(8'h08, 1'b0);
    serve(4, LVL_HI, 1'b0);
    rd_chk("status", 12'h000, 32'h07);
    fire(8'h10, 1'b1);
    serve(0, LVL_OFF, 1'b0);
    rd_chk("status", 12'h000, 32'h87);
    quiet(6);
    iret();
    rd_chk("status", 12'h000, 32'h07);
    iret();
    serve(5, LVL_HI, 1'b0);
    for (int k = 0; k < 4; k++)
    begin
      rd_chk("status", 12'h000, 32'h07 >> k);
      iret();
    end
    $display("preempt test done");
    // Round-robin from a software-written last vector
    irq_level_i <= {NS{LVL_LO}};
    wr(12'h008, 32'h81);
    wr(12'h004, 32'h03);
    fire(8'h25, 1'b0);
    serve(6, LVL_LO, 1'b0);
    rd_chk("last_vector", 12'h004, 32'h06);
    iret();
    serve(1, LVL_LO, 1'b0);
    iret();
    serve(3, LVL_LO, 1'b0);
    iret();
    wr(12'h008, 32'h01);
    rd_chk("last_vector", 12'h004, 32'h03);
    fire(8'h24, 1'b0);
    serve(3, LVL_LO, 1'b0);
    iret();
    serve(6, LVL_LO, 1'b0);
    iret();
    rd_chk("last_vector", 12'h004, 32'h03);
    irq_level_i <= {NS{LVL_MED}};
    wr(12'h008, 32'h82);
    wr(12'h004, 32'h01);
    fire(8'h11, 1'b0);
    serve(1, LVL_MED, 1'b0);
    iret();
    serve(5, LVL_MED, 1'b0);
    iret();
    $display("round robin test done");
    // Vector select is protected; reserved bits always written zero
    irq_level_i <= {NS{LVL_LO}};
    wr(12'h008, 32'h41);
    rd_chk("control", 12'h008, 32'h01);
    ccp_unlock_i <= 1'b1;
    wr(12'h008, 32'h41);
    ccp_unlock_i <= 1'b0;
    rd_chk("control", 12'h008, 32'h41);
    fire(8'h01, 1'b0);
    serve(1, LVL_LO, 1'b1);
    iret();
    ccp_unlock_i <= 1'b1;
    wr(12'h008, 32'h07);
    ccp_unlock_i <= 1'b0;
    wr(12'h004, 32'h00);
    $display("vector select test done");
    // Random level mixes served in bench-predicted order
    for (int it = 0; it < 25; it++)
    begin
      m = NS'(rnd());
      if (m == '0)
        m = 8'h80;
      for (int j = 0; j < NS; j++)
        lv[j] = 2'(1 + rnd() % 3);
      irq_level_i <= lv;
      slow <= rnd() % 2;
      fire(m, 1'b0);
      while (m != '0)
      begin
        b = win(m, lv);
        serve(b + 1, lv[b], 1'b0);
        iret();
        m[b] = 1'b0;
      end
    end
    $display("random test done");
    report_and_stop();
  end
endmodule
